// ===== logic/lcb_params.svh
// Constants of the lock, holdover and configuration register bank.
// Assumes a 20 MHz system clock and 32-bit serial words, address in bits 4:0.
`ifndef LCB_PARAMS_SVH
`define LCB_PARAMS_SVH
// Register addresses carried in the low five bits of each serial word
`define LCB_A_INLOSS 5'h0e
`define LCB_A_MANDAC 5'h0f
`define LCB_A_XTAL 5'h10
`define LCB_A_LFDLY 5'h18
`define LCB_A_RBLOCK 5'h1f
`define LCB_SLOT_NONE 4'hf
`define LCB_SLOT_MANDAC 4'h1
`define LCB_NSLOTS 11
// Reset words, address field included
`define LCB_RST_INLOSS 32'h1200000e
`define LCB_RST_MANDAC 32'h8000800f
`define LCB_RST_XTAL 32'h00000010
`define LCB_RST_LFDLY 32'h000000d8
`define LCB_RST_DACCLK 32'h01010019
`define LCB_RST_L2LOCK 32'h0c08001a
`define LCB_RST_L1REF 32'h1000181b
`define LCB_RST_L2REF 32'h0040301c
`define LCB_RST_CAL 32'h0780061d
`define LCB_RST_L2FB 32'h0200061e
`define LCB_RST_RBLOCK 32'h001f001f
// Field positions
`define LCB_F_ADDR 4:0
`define LCB_F_LOS_EN 28
`define LCB_F_PREDIV_LSB 20
`define LCB_F_HI_TRIP 19:14
`define LCB_F_LO_TRIP 11:6
`define LCB_F_RAIL_EN 5
`define LCB_F_TUNE_DAC_MANUAL_VALUE 31:22
`define LCB_F_MAN_EN 20
`define LCB_F_HO_EXIT 19:6
`define LCB_F_FORCE_HO 5
`define LCB_F_WIN1 7:6
`define LCB_F_DAC_DIV 31:22
`define LCB_F_DLD1 19:6
`define LCB_F_WIN2 31:30
`define LCB_F_DBL 29
`define LCB_F_DLD2 19:6
`define LCB_F_R1 19:6
`define LCB_F_R2 31:20
`define LCB_F_N1 19:6
`define LCB_F_FAST 23
`define LCB_F_P2 26:24
`define LCB_F_N2 22:5
`define LCB_F_RB_LE 21
`define LCB_F_RB_ADDR 20:16
`define LCB_F_WLOCK 5
// Modes and tables
`define LCB_HO_MODE_ON 2'h2
`define LCB_WIN1_TABLE 32'h28140a05
`define LCB_WIN2_TABLE 32'h28140a05
`define LCB_P2_MIN 3'h2
// Timing
`define LCB_CLK_HZ 20000000
`define LCB_LOS_TIMEOUT_NS 1200
`define LCB_LOS_TIMEOUT_CYC ((`LCB_LOS_TIMEOUT_NS * (`LCB_CLK_HZ / 1000000)) / 1000)
`define LCB_RB_LOAD_DELAY 3'h2
`endif

// ===== logic/lcb_pkg.sv
// Types shared by the configuration bank and its serial front end.
// Assumes nothing beyond the constants header.
package lcb_pkg;
  typedef logic [31:0] lcb_word_t;
  typedef enum logic {LCB_TRACK, LCB_HOLD} lcb_ho_state_e;
endpackage : lcb_pkg

// ===== logic/lcb_link_if.sv
// Word hand-over between the serial front end and the register bank.
// Assumes both ends run on sys_clk.
`timescale 1ns/1ns
`default_nettype none
interface lcb_link_if;
  import lcb_pkg::*;
  logic wordValid;
  lcb_word_t wordData;
  lcb_word_t rdWord;
  logic readbackLatchLevel;
  modport serial (output wordValid, output wordData, input rdWord, input readbackLatchLevel);
  modport bank (input wordValid, input wordData, output rdWord, output readbackLatchLevel);
endinterface : lcb_link_if
`default_nettype wire

// ===== logic/lcb_serial_port.sv
// Three-wire serial front end: samples the pins, collects 32-bit words,
// shifts readback data out. Assumes a reset already synchronised to sys_clk.
`timescale 1ns/1ns
`default_nettype none
`include "lcb_params.svh"
module lcb_serial_port (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstnSync,
  // Serial pins
  input wire logic serClk,
  input wire logic serData,
  input wire logic serialLatchEnablePin,
  output logic serReadOut,
  // Bank side
  lcb_link_if.serial link
);
  import lcb_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  logic [2:0] meta_reg;
  logic [2:0] sync_reg;
  logic [1:0] prev_reg;
  lcb_word_t inShift_reg, inShift_next;
  lcb_word_t outShift_reg, outShift_next;
  logic [2:0] loadDly_reg, loadDly_next;
  logic wordValid_reg, wordValid_next;
  lcb_word_t wordData_reg, wordData_next;
  logic clkRise, clkFall, leFall, leEdge;

  assign clkRise = sync_reg[0] && !prev_reg[0];
  assign clkFall = !sync_reg[0] && prev_reg[0];
  assign leFall = !sync_reg[2] && prev_reg[1];
  assign leEdge = sync_reg[2] != prev_reg[1];

  always_comb begin
    inShift_next = inShift_reg;
    outShift_next = outShift_reg;
    loadDly_next = loadDly_reg;
    wordValid_next = 1'b0;
    wordData_next = wordData_reg;
    if (clkRise) begin
      inShift_next = {inShift_reg[30:0], sync_reg[1]};
    end
    if (leFall) begin
      wordValid_next = 1'b1;
      wordData_next = inShift_reg;
    end
    // Reload the readback word two cycles after a latch edge, a cycle before a word written at that edge shows in it
    if (leEdge) begin
      loadDly_next = `LCB_RB_LOAD_DELAY;
    end else if (loadDly_reg != 3'h0) begin
      loadDly_next = loadDly_reg - 3'h1;
    end
    if (loadDly_reg == 3'h1) begin
      outShift_next = link.rdWord;
    end else if (clkFall && sync_reg[2] == link.readbackLatchLevel) begin
      outShift_next = {outShift_reg[30:0], 1'b0};
    end
  end

  // First stage feeds the second only
  always_ff @(posedge sys_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      meta_reg <= 3'h0;
      sync_reg <= 3'h0;
      prev_reg <= 2'h0;
      inShift_reg <= 32'h0;
      outShift_reg <= 32'h0;
      loadDly_reg <= 3'h0;
      wordValid_reg <= 1'b0;
      wordData_reg <= 32'h0;
    end else begin
      meta_reg <= {serialLatchEnablePin, serData, serClk};
      sync_reg <= meta_reg;
      prev_reg <= {sync_reg[2], sync_reg[0]};
      inShift_reg <= inShift_next;
      outShift_reg <= outShift_next;
      loadDly_reg <= loadDly_next;
      wordValid_reg <= wordValid_next;
      wordData_reg <= wordData_next;
    end
  end

  assign serReadOut = outShift_reg[31];
  assign link.wordValid = wordValid_reg;
  assign link.wordData = wordData_reg;
endmodule : lcb_serial_port
`default_nettype wire

// ===== logic/lcb_pll_config_bank.sv
// Lock-detect, holdover and divider configuration bank of a dual-loop
// clock cleaner, programmed over a three-wire serial link.
// Assumes phase-detector ticks, phase errors and reference edge pulses
// arrive as one-cycle signals already on sys_clk.
//
// What this block does
// - Leave holdover only after loop-one lock held the programmed tick count.
// - Loop-one lock indication rises after programmed consecutive in-window ticks.
// - Loop-two lock state rises after programmed in-window detector ticks.
// - Two-bit code picks loop-one lock window; code three means 40 ns.
// - Tuning DAC updates at loop-one tick rate over a 10-bit divisor.
// - Manual DAC value drives DAC under override; reading returns live DAC.
// - Manual value used only while the override bit is set.
// - Rail trip unlocks loop one only when rail detection is enabled.
// - Six-bit high and low trip distances also force holdover entry.
// - Loss of signal is flagged per reference while detection is enabled.
// - Each reference has its own divide-by-1/2/4/8 pre-divider.
// - Loop-one reference divider is 14 bits, default 96.
// - Loop-one feedback divider is 14 bits, default 192.
// - Loop-two reference divider is 12 bits, default 4.
// - Loop-two feedback divider is 18 bits, default 48.
// - Loop-two prescaler divides by 2 to 7, default 2.
// - Doubler bit doubles the loop-two reference, cleared by default.
// - Fast detector bit defaults set; host sets it above 100 MHz.
// - Readback returns the register chosen by a five-bit address field.
// - Write-protect bit blocks writes to registers 0 through 30.
// - Loss of loop-one lock enters holdover when holdover mode is 2.
// - A word takes effect on the latch pin falling edge.
`timescale 1ns/1ns
`default_nettype none
`include "lcb_params.svh"
module lcb_pll_config_bank (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Serial programming pins
  input wire logic serClk,
  input wire logic serData,
  input wire logic serialLatchEnablePin,
  output logic serReadOut,
  // Phase-detector timing
  input wire logic pd1Tick,
  input wire logic pd2Tick,
  input wire logic [7:0] loop1PhaseErrNs,
  input wire logic [7:0] loop2PhaseErrNs,
  // Reference activity and holdover mode from the mode register
  input wire logic [2:0] refEdge,
  input wire logic [1:0] holdoverMode,
  // Tuning DAC
  input wire logic [9:0] dacTrackValue,
  output logic [9:0] dacValue,
  // Status
  output lcb_pkg::lcb_ho_state_e holdoverState,
  output logic loop1LockInd,
  output logic loop2LockInd,
  output logic [2:0] refLoss,
  // Divider settings
  output logic [2:0][3:0] refPreDivRatio,
  output logic [13:0] loop1RefDivider,
  output logic [13:0] loop1FeedbackDivider,
  output logic [11:0] loop2RefDivider,
  output logic [17:0] loop2FeedbackDivider,
  output logic [2:0] loop2FeedbackPrescaler,
  output logic loop2RefDoublerEnable,
  output logic loop2FastDetectorEnable
);
  import lcb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic [1:0] rstSync_reg;
  logic rstnSync;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rstSync_reg <= 2'h0;
    end else begin
      rstSync_reg <= {rstSync_reg[0], 1'b1};
    end
  end
  assign rstnSync = rstSync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // Serial front end
  lcb_link_if link ();
  lcb_serial_port u_serial (
    .sys_clk(sys_clk),
    .rstnSync(rstnSync),
    .serClk(serClk),
    .serData(serData),
    .serialLatchEnablePin(serialLatchEnablePin),
    .serReadOut(serReadOut),
    .link(link.serial)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  localparam lcb_word_t RST_WORDS [0:`LCB_NSLOTS-1] = '{
    `LCB_RST_INLOSS, `LCB_RST_MANDAC, `LCB_RST_XTAL, `LCB_RST_LFDLY,
    `LCB_RST_DACCLK, `LCB_RST_L2LOCK, `LCB_RST_L1REF, `LCB_RST_L2REF,
    `LCB_RST_CAL, `LCB_RST_L2FB, `LCB_RST_RBLOCK};

  // Addresses outside this bank map to no slot and are dropped
  function automatic logic [3:0] slotOf(input logic [4:0] a);
    if (a == `LCB_A_INLOSS) begin
      slotOf = 4'h0;
    end else if (a == `LCB_A_MANDAC) begin
      slotOf = `LCB_SLOT_MANDAC;
    end else if (a == `LCB_A_XTAL) begin
      slotOf = 4'h2;
    end else if (a >= `LCB_A_LFDLY) begin
      slotOf = 4'(a - `LCB_A_LFDLY) + 4'h3;
    end else begin
      slotOf = `LCB_SLOT_NONE;
    end
  endfunction : slotOf

  // Returns {target reached, next count}; count saturates at the target
  function automatic logic [14:0] qualStep(input logic [13:0] cnt,
                                           input logic [13:0] target,
                                           input logic hit);
    logic [14:0] inc;
    inc = {1'b0, cnt} + 15'h1;
    if (!hit) begin
      qualStep = 15'h0;
    end else begin
      qualStep = {inc >= {1'b0, target}, (cnt < target) ? inc[13:0] : cnt};
    end
  endfunction : qualStep

  lcb_word_t regs_reg [0:`LCB_NSLOTS-1];
  lcb_word_t regs_next [0:`LCB_NSLOTS-1];
  lcb_word_t rdWord_reg, rdWord_next;
  logic [9:0] dacDivCnt_reg, dacDivCnt_next, dacValue_reg, dacValue_next;
  logic [3:0] wrSlot, rbSlot;
  logic wrAllowed;

  always_comb begin
    regs_next = regs_reg;
    wrSlot = slotOf(link.wordData[`LCB_F_ADDR]);
    wrAllowed = (link.wordData[`LCB_F_ADDR] == `LCB_A_RBLOCK)
      || !regs_reg[10][`LCB_F_WLOCK];
    if (link.wordValid && wrAllowed && wrSlot != `LCB_SLOT_NONE) begin
      regs_next[wrSlot] = link.wordData;
    end
  end

  always_ff @(posedge sys_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      regs_reg <= RST_WORDS;
    end else begin
      regs_reg <= regs_next;
    end
  end

  // Field views
  logic losDetectEnable, tuneRailDetectEnable, tuneDacOverrideEnable, forceHoldover;
  logic [5:0] highTrip, lowTrip;
  logic [9:0] tuneDacManualValue, dacClkDiv;
  logic [13:0] holdoverExitLockCount, loop1LockQualifyCount, loop2LockQualifyCount;
  logic [1:0] loop1LockWindow, loop2LockWindow;
  assign losDetectEnable = regs_reg[0][`LCB_F_LOS_EN];
  assign highTrip = regs_reg[0][`LCB_F_HI_TRIP];
  assign lowTrip = regs_reg[0][`LCB_F_LO_TRIP];
  assign tuneRailDetectEnable = regs_reg[0][`LCB_F_RAIL_EN];
  assign tuneDacManualValue = regs_reg[1][`LCB_F_TUNE_DAC_MANUAL_VALUE];
  assign tuneDacOverrideEnable = regs_reg[1][`LCB_F_MAN_EN];
  assign holdoverExitLockCount = regs_reg[1][`LCB_F_HO_EXIT];
  assign forceHoldover = regs_reg[1][`LCB_F_FORCE_HO];
  assign loop1LockWindow = regs_reg[3][`LCB_F_WIN1];
  assign dacClkDiv = regs_reg[4][`LCB_F_DAC_DIV];
  assign loop1LockQualifyCount = regs_reg[4][`LCB_F_DLD1];
  assign loop2LockWindow = regs_reg[5][`LCB_F_WIN2];
  assign loop2LockQualifyCount = regs_reg[5][`LCB_F_DLD2];

  ////////////////////////////////////////////////////////////////////////////
  // Readback
  always_comb begin
    rbSlot = slotOf(regs_reg[10][`LCB_F_RB_ADDR]);
    rdWord_next = 32'h0;
    if (rbSlot != `LCB_SLOT_NONE) begin
      rdWord_next = regs_reg[rbSlot];
    end
    if (rbSlot == `LCB_SLOT_MANDAC) begin
      rdWord_next[`LCB_F_TUNE_DAC_MANUAL_VALUE] = dacValue_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lock detection, holdover and tuning DAC
  lcb_ho_state_e ho_reg, ho_next;
  logic [13:0] lock1Cnt_reg, lock1Cnt_next, lock2Cnt_reg, lock2Cnt_next;
  logic [13:0] hoCnt_reg, hoCnt_next;
  logic lock1_reg, lock1_next, lock2_reg, lock2_next;
  logic [7:0] win1Ns, win2Ns;
  logic in1, in2, atRail, railTrip, dacTick, exitHit;
  logic [14:0] q1, q2, qh;

  always_comb begin
    win1Ns = 8'(`LCB_WIN1_TABLE >> {loop1LockWindow, 3'h0});
    win2Ns = 8'(`LCB_WIN2_TABLE >> {loop2LockWindow, 3'h0});
    in1 = loop1PhaseErrNs <= win1Ns;
    in2 = loop2PhaseErrNs <= win2Ns;
    // Each trip step is sixteen DAC codes
    atRail = (dacValue_reg >= 10'h3ff - {highTrip, 4'h0})
      || (dacValue_reg <= {lowTrip, 4'h0});
    // Held value in holdover would keep tripping forever, so only track mode trips
    railTrip = tuneRailDetectEnable && atRail && ho_reg == LCB_TRACK;
    q1 = qualStep(lock1Cnt_reg, loop1LockQualifyCount, in1);
    q2 = qualStep(lock2Cnt_reg, loop2LockQualifyCount, in2);
    qh = qualStep(hoCnt_reg, holdoverExitLockCount, lock1_reg);

    lock1Cnt_next = lock1Cnt_reg;
    lock1_next = lock1_reg;
    if (railTrip) begin
      lock1Cnt_next = 14'h0;
      lock1_next = 1'b0;
    end else if (pd1Tick) begin
      lock1Cnt_next = q1[13:0];
      lock1_next = q1[14];
    end
    lock2Cnt_next = lock2Cnt_reg;
    lock2_next = lock2_reg;
    if (pd2Tick) begin
      lock2Cnt_next = q2[13:0];
      lock2_next = q2[14];
    end

    ho_next = ho_reg;
    hoCnt_next = hoCnt_reg;
    exitHit = 1'b0;
    unique case (ho_reg)
      LCB_TRACK: begin
        hoCnt_next = 14'h0;
        if (forceHoldover || railTrip
            || (lock1_reg && !lock1_next && holdoverMode == `LCB_HO_MODE_ON)) begin
          ho_next = LCB_HOLD;
        end
      end
      LCB_HOLD: begin
        if (pd1Tick) begin
          hoCnt_next = qh[13:0];
          exitHit = qh[14];
        end
        if (exitHit && !forceHoldover) begin
          ho_next = LCB_TRACK;
        end
      end
    endcase

    dacDivCnt_next = dacDivCnt_reg;
    dacTick = 1'b0;
    if (pd1Tick) begin
      if (dacDivCnt_reg + 10'h1 >= dacClkDiv) begin
        dacDivCnt_next = 10'h0;
        dacTick = 1'b1;
      end else begin
        dacDivCnt_next = dacDivCnt_reg + 10'h1;
      end
    end
    dacValue_next = dacValue_reg;
    if (dacTick) begin
      if (tuneDacOverrideEnable) begin
        dacValue_next = tuneDacManualValue;
      end else if (ho_reg == LCB_TRACK) begin
        dacValue_next = dacTrackValue;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      ho_reg <= LCB_TRACK;
      lock1Cnt_reg <= 14'h0;
      lock2Cnt_reg <= 14'h0;
      hoCnt_reg <= 14'h0;
      lock1_reg <= 1'b0;
      lock2_reg <= 1'b0;
      dacDivCnt_reg <= 10'h0;
      dacValue_reg <= 10'h200;
      rdWord_reg <= 32'h0;
    end else begin
      ho_reg <= ho_next;
      lock1Cnt_reg <= lock1Cnt_next;
      lock2Cnt_reg <= lock2Cnt_next;
      hoCnt_reg <= hoCnt_next;
      lock1_reg <= lock1_next;
      lock2_reg <= lock2_next;
      dacDivCnt_reg <= dacDivCnt_next;
      dacValue_reg <= dacValue_next;
      rdWord_reg <= rdWord_next;
    end
  end

  assign link.rdWord = rdWord_reg;
  assign link.readbackLatchLevel = regs_reg[10][`LCB_F_RB_LE];
  assign dacValue = dacValue_reg;
  assign holdoverState = ho_reg;
  assign loop1LockInd = lock1_reg;
  assign loop2LockInd = lock2_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Reference loss and pre-dividers
  localparam logic [7:0] LOS_CYC = 8'(`LCB_LOS_TIMEOUT_CYC);
  logic [2:0][7:0] losCnt_reg, losCnt_next;
  logic [2:0] refLoss_reg, refLoss_next;
  logic [2:0][3:0] preDiv_reg, preDiv_next;

  for (genvar i = 0; i < 3; i++) begin : g_ref
    always_comb begin
      losCnt_next[i] = losCnt_reg[i];
      if (refEdge[i] || !losDetectEnable) begin
        losCnt_next[i] = 8'h0;
      end else if (losCnt_reg[i] != LOS_CYC) begin
        losCnt_next[i] = losCnt_reg[i] + 8'h1;
      end
      refLoss_next[i] = losDetectEnable && losCnt_next[i] == LOS_CYC;
      preDiv_next[i] = 4'h1 << regs_reg[6][`LCB_F_PREDIV_LSB + 2*i +: 2];
    end
    always_ff @(posedge sys_clk or negedge rstnSync) begin
      if (!rstnSync) begin
        losCnt_reg[i] <= 8'h0;
        refLoss_reg[i] <= 1'b0;
        preDiv_reg[i] <= 4'h1;
      end else begin
        losCnt_reg[i] <= losCnt_next[i];
        refLoss_reg[i] <= refLoss_next[i];
        preDiv_reg[i] <= preDiv_next[i];
      end
    end
  end

  assign refLoss = refLoss_reg;
  assign refPreDivRatio = preDiv_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Divider settings; a zero divisor is treated as one, a prescaler below two as two
  logic [13:0] r1_reg, r1_next, n1_reg, n1_next;
  logic [11:0] r2_reg, r2_next;
  logic [17:0] n2_reg, n2_next;
  logic [2:0] p2_reg, p2_next;
  logic dbl_reg, dbl_next, fast_reg, fast_next;

  always_comb begin
    r1_next = regs_reg[6][`LCB_F_R1];
    n1_next = regs_reg[7][`LCB_F_N1];
    r2_next = regs_reg[7][`LCB_F_R2];
    n2_next = regs_reg[9][`LCB_F_N2];
    p2_next = regs_reg[9][`LCB_F_P2];
    if (r1_next == 14'h0) begin
      r1_next = 14'h1;
    end
    if (n1_next == 14'h0) begin
      n1_next = 14'h1;
    end
    if (r2_next == 12'h0) begin
      r2_next = 12'h1;
    end
    if (n2_next == 18'h0) begin
      n2_next = 18'h1;
    end
    if (p2_next < `LCB_P2_MIN) begin
      p2_next = `LCB_P2_MIN;
    end
    dbl_next = regs_reg[5][`LCB_F_DBL];
    fast_next = regs_reg[8][`LCB_F_FAST];
  end

  always_ff @(posedge sys_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      r1_reg <= 14'h60;
      n1_reg <= 14'hc0;
      r2_reg <= 12'h4;
      n2_reg <= 18'h30;
      p2_reg <= 3'h2;
      dbl_reg <= 1'b0;
      fast_reg <= 1'b1;
    end else begin
      r1_reg <= r1_next;
      n1_reg <= n1_next;
      r2_reg <= r2_next;
      n2_reg <= n2_next;
      p2_reg <= p2_next;
      dbl_reg <= dbl_next;
      fast_reg <= fast_next;
    end
  end

  assign loop1RefDivider = r1_reg;
  assign loop1FeedbackDivider = n1_reg;
  assign loop2RefDivider = r2_reg;
  assign loop2FeedbackDivider = n2_reg;
  assign loop2FeedbackPrescaler = p2_reg;
  assign loop2RefDoublerEnable = dbl_reg;
  assign loop2FastDetectorEnable = fast_reg;
endmodule : lcb_pll_config_bank
`default_nettype wire

// ===== testbench/lcb_pll_config_bank_monitor.sv
// Checker for the configuration bank: lock, holdover and divider settings.
// Assumes it is bound to the bank top and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module lcb_pll_config_bank_monitor (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Timing and mode
  input wire logic pd1Tick,
  input wire logic pd2Tick,
  input wire logic [7:0] loop1PhaseErrNs,
  input wire logic [1:0] holdoverMode,
  // Status and settings
  input wire lcb_pkg::lcb_ho_state_e holdoverState,
  input wire logic loop1LockInd,
  input wire logic loop2LockInd,
  input wire logic [2:0][3:0] refPreDivRatio,
  input wire logic [13:0] loop1RefDivider,
  input wire logic [17:0] loop2FeedbackDivider,
  input wire logic [2:0] loop2FeedbackPrescaler
);
  import lcb_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // The widest window code is 40 ns, so no qualifying tick can exceed it
  sequence sQualTick;
    $past(pd1Tick) && $past(loop1PhaseErrNs) <= 8'h28;
  endsequence
  sequence sLockLoss;
    $fell(loop1LockInd) && holdoverMode == 2'h2 && $past(holdoverState) == LCB_TRACK;
  endsequence
  AST_LOCK1_RISE: assert property ($rose(loop1LockInd) |-> sQualTick)
    else $error("loop one lock rose without an in-window tick");
  AST_LOCK2_RISE: assert property ($rose(loop2LockInd) |-> $past(pd2Tick))
    else $error("loop two lock rose without a tick");
  AST_HO_ENTER: assert property (sLockLoss |-> ##[0:1] holdoverState == LCB_HOLD)
    else $error("holdover not entered on lock loss");
  AST_HO_EXIT: assert property ($fell(holdoverState == LCB_HOLD) |->
    $past(loop1LockInd) && $past(pd1Tick)) else $error("holdover left without lock");
  AST_R1_RANGE: assert property (loop1RefDivider != 14'h0000)
    else $error("loop one reference divider zero");
  AST_N2_RANGE: assert property (loop2FeedbackDivider != 18'h00000)
    else $error("loop two feedback divider zero");
  AST_P2_RANGE: assert property (loop2FeedbackPrescaler >= 3'h2)
    else $error("prescaler below two");
  AST_PREDIV: assert property ($onehot(refPreDivRatio[0]) && $onehot(refPreDivRatio[1])
    && $onehot(refPreDivRatio[2])) else $error("pre-divider ratio not 1, 2, 4 or 8");
endmodule : lcb_pll_config_bank_monitor
bind lcb_pll_config_bank lcb_pll_config_bank_monitor u_lcb_pll_config_bank_monitor (
  .sys_clk, .rstn, .pd1Tick, .pd2Tick, .loop1PhaseErrNs, .holdoverMode, .holdoverState,
  .loop1LockInd, .loop2LockInd, .refPreDivRatio, .loop1RefDivider, .loop2FeedbackDivider,
  .loop2FeedbackPrescaler);
`default_nettype wire

// ===== testbench/lcb_host_model.sv
// Host controller on the three-wire programming link.
// Assumes sys_clk only paces it; pins change 5 ns after an edge.
`timescale 1ns/1ns
`default_nettype none
module lcb_host_model (
  // Clock
  input wire logic sys_clk,
  // Serial pins
  output logic serClk,
  output logic serData,
  output logic serialLatchEnablePin,
  input wire logic serReadOut
);
  import lcb_pkg::*;
  initial {serClk, serData, serialLatchEnablePin} = 3'h0;
  task automatic waitCyc(input int n);
    repeat (n) @(posedge sys_clk);
    #5;
  endtask : waitCyc
  // Phases of 4 and 5 cycles leave room for the two-flop pin sampling
  task automatic pulse();
    serClk = 1'b1;
    waitCyc(4);
    serClk = 1'b0;
    waitCyc(5);
  endtask : pulse
  task automatic sendWord(input lcb_word_t w);
    serialLatchEnablePin = 1'b1;
    waitCyc(8);
    for (int i = 31; i >= 0; i--) begin
      serData = w[i];
      waitCyc(4);
      pulse();
    end
    serialLatchEnablePin = 1'b0;
    waitCyc(10);
  endtask : sendWord
  // Zeros shifted in here form an address-0 word, which the bank ignores
  task automatic readWord(output lcb_word_t r);
    serData = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      r[i] = serReadOut;
      pulse();
    end
  endtask : readWord
endmodule : lcb_host_model
`default_nettype wire

// ===== testbench/lcb_pll_config_bank_tb_top.sv
// Self-checking bench of the configuration bank with a host model.
// Assumes holdover mode starts at its enabling code.
`timescale 1ns/1ns
`default_nettype none
`include "lcb_params.svh"
`define CHK(n, e, a) begin totalChecks++; if ((a) !== (e)) begin errCount++; \
  $display("FAIL %s expected %0h seen %0h", n, e, a); end end
module lcb_pll_config_bank_tb_top;
  import lcb_pkg::*;
  logic sys_clk, rstn, serClk, serData, serialLatchEnablePin, serReadOut;
  logic pd1Tick, pd2Tick, refOn, dbl, fast, l1, l2;
  logic [7:0] err1;
  logic [1:0] hoMode = `LCB_HO_MODE_ON;
  logic [2:0] refEdge, refLoss, p2;
  logic [9:0] dacTrack, dac;
  logic [2:0][3:0] ratio;
  logic [13:0] r1, n1;
  logic [11:0] r2;
  logic [17:0] n2;
  lcb_ho_state_e hs;
  lcb_word_t rw;
  int errCount, totalChecks, cyc = 0;
  lcb_pll_config_bank u_lcb_pll_config_bank (.sys_clk, .rstn, .serClk, .serData,
    .serialLatchEnablePin, .serReadOut, .pd1Tick, .pd2Tick, .loop1PhaseErrNs(err1),
    .loop2PhaseErrNs(err1), .refEdge, .holdoverMode(hoMode), .dacTrackValue(dacTrack),
    .dacValue(dac), .holdoverState(hs), .loop1LockInd(l1), .loop2LockInd(l2), .refLoss,
    .refPreDivRatio(ratio), .loop1RefDivider(r1), .loop1FeedbackDivider(n1),
    .loop2RefDivider(r2), .loop2FeedbackDivider(n2), .loop2FeedbackPrescaler(p2),
    .loop2RefDoublerEnable(dbl), .loop2FastDetectorEnable(fast));
  lcb_host_model u_lcb_host_model (.sys_clk, .serClk, .serData, .serialLatchEnablePin,
    .serReadOut);
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    refEdge <= (refOn && cyc[2:0] == 3'h0) ? 3'h7 : 3'h0;
    if (cyc == 40000) begin
      errCount++;
      summarize();
    end
  end
  task automatic summarize();
    if (errCount == 0 && totalChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #5;
  endtask : step
  task automatic wr(input lcb_word_t w);
    u_lcb_host_model.sendWord(w);
  endtask : wr
  task automatic tick(input int n, input logic [7:0] e);
    err1 = e;
    repeat (n) begin
      {pd1Tick, pd2Tick} = 2'h3;
      step(1);
      {pd1Tick, pd2Tick} = 2'h0;
      step(3);
    end
  endtask : tick
  // A dummy word after the address change makes the shifter reload
  task automatic rdReg(input logic [4:0] a);
    wr({11'h0, a, 10'h0, 1'b0, 5'h1f});
    wr(32'h0);
    u_lcb_host_model.readWord(rw);
  endtask : rdReg
  task automatic tDefaults();
    `CHK("r1", 14'd96, r1)
    `CHK("n1", 14'd192, n1)
    `CHK("r2", 12'd4, r2)
    `CHK("n2", 18'd48, n2)
    `CHK("p2", 3'd2, p2)
    `CHK("dbl", 1'b0, dbl)
    `CHK("fast", 1'b1, fast)
    `CHK("ratio", 12'h111, ratio)
    `CHK("dac", 10'h200, dac)
    rdReg(5'h1f);
    `CHK("rb31", `LCB_RST_RBLOCK, rw)
    rdReg(5'h1b);
    `CHK("rb27", `LCB_RST_L1REF, rw)
  endtask : tDefaults
  task automatic tDividers();
    wr({6'h0, 2'h3, 2'h2, 2'h1, 14'h3fff, 1'b0, 5'h1b});
    wr({12'hfff, 14'h0001, 1'b0, 5'h1c});
    wr({9'h0, 18'h3ffff, 5'h1d});
    wr({9'h0, 18'h3ffff, 5'h1e});
    `CHK("ratio", 12'h842, ratio)
    `CHK("r1", 14'h3fff, r1)
    `CHK("n1", 14'h0001, n1)
    `CHK("r2", 12'hfff, r2)
    `CHK("n2", 18'h3ffff, n2)
    `CHK("p2", 3'd2, p2)
    `CHK("fast", 1'b0, fast)
    wr({5'h0, 3'h7, 1'b0, 18'h00030, 5'h1e});
    wr({8'h0, 1'b1, 18'h00030, 5'h1d});
    `CHK("p2", 3'd7, p2)
  endtask : tDividers
  task automatic tLock();
    wr({10'h004, 2'h0, 14'h0008, 1'b0, 5'h19});
    wr({2'h3, 1'b1, 9'h0, 14'h0004, 1'b0, 5'h1a});
    wr({10'h155, 2'h0, 14'h0004, 1'b0, 5'h0f});
    `CHK("dbl", 1'b1, dbl)
    tick(3, 8'h1e);
    `CHK("l2", 1'b0, l2)
    tick(1, 8'h1e);
    `CHK("l2", 1'b1, l2)
    tick(3, 8'h1e);
    `CHK("l1", 1'b0, l1)
    tick(1, 8'h1e);
    `CHK("l1", 1'b1, l1)
    wr({24'h0, 2'h0, 1'b0, 5'h18});
    tick(1, 8'h1e);
    `CHK("l1", 1'b0, l1)
    `CHK("hold", LCB_HOLD, hs)
    tick(10, 8'h04);
    `CHK("hold", LCB_HOLD, hs)
    tick(6, 8'h04);
    `CHK("track", LCB_TRACK, hs)
  endtask : tLock
  task automatic tManualDac();
    tick(4, 8'h04);
    `CHK("dac", 10'h2aa, dac)
    wr({10'h155, 1'b0, 1'b1, 14'h0004, 1'b0, 5'h0f});
    tick(4, 8'h04);
    `CHK("dac", 10'h155, dac)
    wr({10'h0aa, 2'h0, 14'h0004, 1'b0, 5'h0f});
    tick(4, 8'h04);
    rdReg(5'h0f);
    `CHK("rbdac", 10'h2aa, rw[31:22])
    hoMode = 2'h0;
    tick(1, 8'h1e);
    `CHK("track", LCB_TRACK, hs)
    hoMode = `LCB_HO_MODE_ON;
  endtask : tManualDac
  task automatic tRailLos();
    dacTrack = 10'h005;
    tick(8, 8'h04);
    `CHK("l1", 1'b1, l1)
    wr({3'h0, 1'b1, 8'h0, 6'h00, 2'h0, 6'h01, 1'b1, 5'h0e});
    tick(1, 8'h04);
    `CHK("l1", 1'b0, l1)
    `CHK("hold", LCB_HOLD, hs)
    refOn = 1'b0;
    step(40);
    `CHK("los", 3'h7, refLoss)
    wr(32'h0000000e);
    `CHK("los", 3'h0, refLoss)
    refOn = 1'b1;
  endtask : tRailLos
  task automatic tWriteLock();
    wr({11'h0, 5'h1f, 10'h0, 1'b1, 5'h1f});
    wr({12'h0, 14'd100, 1'b0, 5'h1b});
    `CHK("r1", 14'h3fff, r1)
    wr({11'h0, 5'h1f, 16'h001f});
    wr({12'h0, 14'd100, 1'b0, 5'h1b});
    `CHK("r1", 14'd100, r1)
  endtask : tWriteLock
  initial begin
    rstn = 1'b0;
    {pd1Tick, pd2Tick, refOn, err1, errCount, totalChecks} = '0;
    dacTrack = 10'h2aa;
    repeat (20) @(posedge sys_clk);
    #5;
    rstn = 1'b1;
    refOn = 1'b1;
    step(6);
    tDefaults();
    tDividers();
    tLock();
    tManualDac();
    tRailLos();
    tWriteLock();
    summarize();
  end
endmodule : lcb_pll_config_bank_tb_top
`default_nettype wire
